// File: core/tmr_core.sv
// 8-bit timer/counter: registers, counter, modes and flags
//
// Implementation choice: strobed register access.
`include "tmr_params.svh"
`default_nettype none
module tmr_core
   import tmr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [`TMR_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Interrupt side
   input wire logic global_irq_en_i,
   input wire logic [2:0] vector_ack_i,
   output logic irq_match_b_o,
   output logic irq_match_a_o,
   output logic irq_wrap_o,
   // Pins
   input wire logic ext_count_pin_i,
   output logic wave_out_a_o,
   output logic wave_oe_a_o,
   output logic wave_out_b_o,
   output logic wave_oe_b_o
);
   logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, cnt_q, cnt_d;
   logic [7:0] cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d, buf_a_q, buf_a_d, buf_b_q, buf_b_d;
   logic [2:0] flags_q, flags_d, mask_q, mask_d;
   logic [7:0] rdata_q, rdata_d;
   logic down_q, down_d, blk_q, blk_d;
   logic tick, pwm, fast, phase, top_is_a, at_top, at_bottom, wrap_ev;
   logic match_a, match_b, upd, force_a, force_b;
   logic [2:0] mode;
   logic [7:0] top;

   // Register write hit
   function automatic logic hit(input logic [`TMR_ADDR_W-1:0] ofs);
      hit = reg_wr_i && (reg_addr_i == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Tick source
   tmr_tick_gen u_tick (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .clock_source_sel_i(ctrl_b_q[2:0]),
      .ext_count_pin_i(ext_count_pin_i),
      .timer_tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode decode
   always_comb
   begin
      mode = {ctrl_b_q[`TMR_B_MODE_HI], ctrl_a_q[1:0]};
      if (mode == 3'b100 || mode == 3'b110)
         mode = 3'b000;
      phase = (mode[1:0] == 2'b01);
      fast = (mode[1:0] == 2'b11);
      pwm = phase || fast;
      top_is_a = (mode == 3'b010) || mode[2];
      top = top_is_a ? cmp_a_q : `TMR_MAX;
      at_top = (cnt_q == top);
      at_bottom = (cnt_q == `TMR_BOTTOM);
      // Compare buffer update point
      upd = pwm ? (phase ? at_top : at_bottom) : 1'b1;
      // Wrap event per mode, checked on ticks
      if (phase)
         wrap_ev = at_bottom;
      else if (mode == 3'b111)
         wrap_ev = at_top;
      else
         wrap_ev = (cnt_q == `TMR_MAX);
      wrap_ev = wrap_ev && tick;
      match_a = tick && !blk_q && (cnt_q == cmp_a_q);
      match_b = tick && !blk_q && (cnt_q == cmp_b_q);
      force_a = hit(`TMR_OFS_CTRL_B) && reg_wdata_i[`TMR_B_FORCE_A] && !pwm;
      force_b = hit(`TMR_OFS_CTRL_B) && reg_wdata_i[`TMR_B_FORCE_B] && !pwm;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next register and counter values
   always_comb
   begin
      ctrl_a_d = ctrl_a_q;
      ctrl_b_d = ctrl_b_q;
      mask_d = mask_q;
      buf_a_d = buf_a_q;
      buf_b_d = buf_b_q;
      cnt_d = cnt_q;
      down_d = down_q;
      blk_d = blk_q;
      if (hit(`TMR_OFS_CTRL_A))
         ctrl_a_d = reg_wdata_i & `TMR_CTRL_A_MASK;
      if (hit(`TMR_OFS_CTRL_B))
         ctrl_b_d = reg_wdata_i & `TMR_CTRL_B_MASK;
      if (hit(`TMR_OFS_MASK))
         mask_d = reg_wdata_i[2:0];
      if (hit(`TMR_OFS_CMP_A))
         buf_a_d = reg_wdata_i;
      if (hit(`TMR_OFS_CMP_B))
         buf_b_d = reg_wdata_i;
      // Counter advances only on tick; forced strobes never clear it
      if (tick)
      begin
         blk_d = 1'b0;
         if (phase)
         begin
            if (!down_q && at_top)
            begin
               down_d = 1'b1;
               cnt_d = cnt_q - 8'h01;
            end
            else if (down_q && at_bottom)
            begin
               down_d = 1'b0;
               cnt_d = cnt_q + 8'h01;
            end
            else
               cnt_d = down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
         end
         else if (top_is_a && at_top)
            cnt_d = `TMR_BOTTOM;
         else
            cnt_d = cnt_q + 8'h01;
      end
      if (!phase)
         down_d = 1'b0;
      if (hit(`TMR_OFS_COUNT))
      begin
         cnt_d = reg_wdata_i;
         blk_d = 1'b1;
      end
   end

   // Compare values take effect at the mode's update point
   always_comb
   begin
      cmp_a_d = upd ? buf_a_d : cmp_a_q;
      cmp_b_d = upd ? buf_b_d : cmp_b_q;
   end

   // Flags: hardware set wins over acknowledge or write-one clear
   always_comb
   begin
      flags_d = flags_q & ~vector_ack_i;
      if (hit(`TMR_OFS_FLAGS))
         flags_d = flags_d & ~reg_wdata_i[2:0];
      flags_d[`TMR_BIT_B] = flags_d[`TMR_BIT_B] | match_b;
      flags_d[`TMR_BIT_A] = flags_d[`TMR_BIT_A] | match_a;
      flags_d[`TMR_BIT_WRAP] = flags_d[`TMR_BIT_WRAP] | wrap_ev;
   end

   // Read data, one cycle after the strobe
   always_comb
   begin
      rdata_d = 8'h00;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `TMR_OFS_CTRL_A: rdata_d = ctrl_a_q;
            `TMR_OFS_CTRL_B: rdata_d = ctrl_b_q;
            `TMR_OFS_COUNT: rdata_d = cnt_q;
            `TMR_OFS_CMP_A: rdata_d = buf_a_q;
            `TMR_OFS_CMP_B: rdata_d = buf_b_q;
            `TMR_OFS_FLAGS: rdata_d = {5'h00, flags_q};
            `TMR_OFS_MASK: rdata_d = {5'h00, mask_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_a_q <= `TMR_RST_BYTE;
         ctrl_b_q <= `TMR_RST_BYTE;
         cnt_q <= `TMR_RST_BYTE;
         cmp_a_q <= `TMR_RST_BYTE;
         cmp_b_q <= `TMR_RST_BYTE;
         buf_a_q <= `TMR_RST_BYTE;
         buf_b_q <= `TMR_RST_BYTE;
         flags_q <= 3'h0;
         mask_q <= 3'h0;
         rdata_q <= `TMR_RST_BYTE;
         down_q <= 1'b0;
         blk_q <= 1'b0;
      end
      else
      begin
         ctrl_a_q <= ctrl_a_d;
         ctrl_b_q <= ctrl_b_d;
         cnt_q <= cnt_d;
         cmp_a_q <= cmp_a_d;
         cmp_b_q <= cmp_b_d;
         buf_a_q <= buf_a_d;
         buf_b_q <= buf_b_d;
         flags_q <= flags_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
         down_q <= down_d;
         blk_q <= blk_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // Interrupt requests
   assign irq_match_b_o = global_irq_en_i & mask_q[`TMR_BIT_B] & flags_q[`TMR_BIT_B];
   assign irq_match_a_o = global_irq_en_i & mask_q[`TMR_BIT_A] & flags_q[`TMR_BIT_A];
   assign irq_wrap_o = global_irq_en_i & mask_q[`TMR_BIT_WRAP] & flags_q[`TMR_BIT_WRAP];

   ////////////////////////////////////////////////////////////////////////
   // Waveform units
   tmr_wave_unit u_wave_a (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .match_i(match_a),
      .force_i(force_a),
      .pwm_i(pwm),
      .fast_i(fast),
      .at_bottom_i(at_bottom && tick),
      .up_i(!down_q),
      .out_mode_i(ctrl_a_q[`TMR_A_OUT_A_HI -: 2]),
      .wave_out_o(wave_out_a_o),
      .wave_oe_o(wave_oe_a_o)
   );

   tmr_wave_unit u_wave_b (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .match_i(match_b),
      .force_i(force_b),
      .pwm_i(pwm),
      .fast_i(fast),
      .at_bottom_i(at_bottom && tick),
      .up_i(!down_q),
      .out_mode_i(ctrl_a_q[`TMR_A_OUT_B_HI -: 2]),
      .wave_out_o(wave_out_b_o),
      .wave_oe_o(wave_oe_b_o)
   );
endmodule // tmr_core
`default_nettype wire

// File: core/tmr_params.svh
// Register offsets, field positions, masks, reset values, counter limits and prescaler width of the 8-bit timer
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_ADDR_W 8
`define TMR_OFS_CTRL_A 8'h44
`define TMR_OFS_CTRL_B 8'h45
`define TMR_OFS_COUNT 8'h46
`define TMR_OFS_CMP_A 8'h47
`define TMR_OFS_CMP_B 8'h48
`define TMR_OFS_FLAGS 8'h35
`define TMR_OFS_MASK 8'h6E
`define TMR_RST_BYTE 8'h00
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_B_FORCE_A 7
`define TMR_B_FORCE_B 6
`define TMR_B_MODE_HI 3
`define TMR_A_OUT_A_HI 7
`define TMR_A_OUT_B_HI 5
`define TMR_BIT_B 2
`define TMR_BIT_A 1
`define TMR_BIT_WRAP 0
`define TMR_CTRL_A_MASK 8'hF3
`define TMR_CTRL_B_MASK 8'h0F
`define TMR_LOW3_MASK 8'h07
`define TMR_PRE_W 10
`endif
`default_nettype none
`default_nettype wire

// File: core/tmr_pkg.sv
// Types shared by the timer modules
`default_nettype none
package tmr_pkg;
   // Clock source codes
   typedef enum logic [2:0] {
      TMR_CS_STOP, TMR_CS_DIV1, TMR_CS_DIV8, TMR_CS_DIV64,
      TMR_CS_DIV256, TMR_CS_DIV1024, TMR_CS_EXT_FALL, TMR_CS_EXT_RISE
   } tmr_cs_e;
   // Output actions on a match in non-PWM modes
   typedef enum logic [1:0] {TMR_OM_OFF, TMR_OM_TOGGLE, TMR_OM_CLEAR, TMR_OM_SET} tmr_om_e;
endpackage : tmr_pkg
`default_nettype wire

// File: core/tmr_tick_gen.sv
// Timer tick source: prescaler taps and synchronised external count pin
`include "tmr_params.svh"
`default_nettype none
module tmr_tick_gen
   import tmr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Control
   input wire logic [2:0] clock_source_sel_i,
   input wire logic ext_count_pin_i,
   // Tick
   output logic timer_tick_o
);
   logic [`TMR_PRE_W-1:0] pre_q, pre_d;
   logic sync1_q, sync2_q, prev_q;
   logic sync1_d, sync2_d, prev_d;
   logic running;

   ////////////////////////////////////////////////////////////////////////
   // Next-state: prescaler runs while any clock source is chosen
   always_comb
   begin
      running = (clock_source_sel_i != TMR_CS_STOP);
      pre_d = running ? pre_q + `TMR_PRE_W'(1) : '0;
      sync1_d = ext_count_pin_i;
      sync2_d = sync1_q;
      prev_d = sync2_q;
   end

   // Registers
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         pre_q <= '0;
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
      end
   end

   // Tick selection, a one-cycle enable
   always_comb
   begin
      unique case (tmr_cs_e'(clock_source_sel_i))
         TMR_CS_STOP: timer_tick_o = 1'b0;
         TMR_CS_DIV1: timer_tick_o = 1'b1;
         TMR_CS_DIV8: timer_tick_o = (pre_q[2:0] == 3'h7);
         TMR_CS_DIV64: timer_tick_o = (pre_q[5:0] == 6'h3F);
         TMR_CS_DIV256: timer_tick_o = (pre_q[7:0] == 8'hFF);
         TMR_CS_DIV1024: timer_tick_o = (pre_q == 10'h3FF);
         TMR_CS_EXT_FALL: timer_tick_o = prev_q & ~sync2_q;
         TMR_CS_EXT_RISE: timer_tick_o = ~prev_q & sync2_q;
      endcase
   end
endmodule // tmr_tick_gen
`default_nettype wire

// File: core/tmr_wave_unit.sv
// One compare channel: action on a match from the core and waveform output
`include "tmr_params.svh"
`default_nettype none
module tmr_wave_unit
   import tmr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Match inputs
   input wire logic match_i,
   input wire logic force_i,
   input wire logic pwm_i,
   input wire logic fast_i,
   input wire logic at_bottom_i,
   input wire logic up_i,
   input wire logic [1:0] out_mode_i,
   // Pin
   output logic wave_out_o,
   output logic wave_oe_o
);
   logic wave_q, wave_d;

   ////////////////////////////////////////////////////////////////////////
   // Next waveform level
   always_comb
   begin
      wave_d = wave_q;
      if (!pwm_i)
      begin
         if (match_i || force_i)
         begin
            unique case (tmr_om_e'(out_mode_i))
               TMR_OM_OFF: wave_d = wave_q;
               TMR_OM_TOGGLE: wave_d = ~wave_q;
               TMR_OM_CLEAR: wave_d = 1'b0;
               TMR_OM_SET: wave_d = 1'b1;
            endcase
         end
      end
      else if (out_mode_i[1])
      begin
         if (fast_i && at_bottom_i)
            wave_d = ~out_mode_i[0];
         else if (match_i)
            wave_d = fast_i ? out_mode_i[0] : (up_i ~^ out_mode_i[0]);
      end
      else if (out_mode_i[0] && match_i)
         wave_d = ~wave_q;
   end

   // Register
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         wave_q <= 1'b0;
      else
         wave_q <= wave_d;
   end

   assign wave_out_o = wave_q;
   assign wave_oe_o = (out_mode_i != 2'b00);
endmodule // tmr_wave_unit
`default_nettype wire

// File: test/tmr_core_props.sv
// Assertions on register port, request gating and pin enables of the timer
`include "tmr_params.svh"
`default_nettype none
module tmr_core_props
   import tmr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [`TMR_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Interrupt side
   input wire logic global_irq_en_i,
   input wire logic [2:0] vector_ack_i,
   input wire logic irq_match_b_o,
   input wire logic irq_match_a_o,
   input wire logic irq_wrap_o,
   // Pins
   input wire logic ext_count_pin_i,
   input wire logic wave_out_a_o,
   input wire logic wave_oe_a_o,
   input wire logic wave_out_b_o,
   input wire logic wave_oe_b_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Any request line high
   wire any_irq = irq_match_b_o | irq_match_a_o | irq_wrap_o;

   // Write then read of one place returns the writable bits
   property back_p(ofs, msk);
      reg_wr_i && reg_addr_i == ofs ##1 reg_rd_i && reg_addr_i == ofs
         |=> reg_rdata_o == ($past(reg_wdata_i, 2) & msk);
   endproperty

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   rd_idle_zero_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
   unmapped_zero_a: assert property (reg_rd_i && reg_addr_i[7] |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   mask_back_a: assert property (back_p(`TMR_OFS_MASK, 8'h07))
      else $error("mask readback wrong");
   ctrlb_back_a: assert property (back_p(`TMR_OFS_CTRL_B, 8'h0F))
      else $error("control b readback wrong");
   ctrla_back_a: assert property (back_p(`TMR_OFS_CTRL_A, 8'hF3))
      else $error("control a readback wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Requests and pins
   irq_gate_a: assert property (!global_irq_en_i |-> !any_irq)
      else $error("request while global enable low");
   reset_quiet_a: assert property ($fell(sys_rst_i) |-> !any_irq)
      else $error("request right after reset");
   reset_oe_a: assert property ($fell(sys_rst_i) |-> !wave_oe_a_o && !wave_oe_b_o)
      else $error("pin enabled right after reset");
   oe_steady_a: assert property (!reg_wr_i |=> $stable(wave_oe_a_o) && $stable(wave_oe_b_o))
      else $error("pin enable moved without a write");

   // Main scenarios
   wrap_req_c: cover property (irq_wrap_o);
   wave_a_c: cover property (wave_oe_a_o && wave_out_a_o);
   wave_b_c: cover property (wave_oe_b_o && wave_out_b_o);
endmodule // tmr_core_props
`default_nettype wire

// File: test/tmr_core_bench.sv
// Self-checking bench of the 8-bit timer core
`include "tmr_params.svh"
`default_nettype none
module tmr_core_bench
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ra = `TMR_OFS_CTRL_A, rb = `TMR_OFS_CTRL_B, rc = `TMR_OFS_COUNT;
   localparam logic [7:0] rpa = `TMR_OFS_CMP_A, rpb = `TMR_OFS_CMP_B;
   localparam logic [7:0] rf = `TMR_OFS_FLAGS, rm = `TMR_OFS_MASK;
   logic clk, rst, wr, rd, gie, ext, ia, ib, iw, wa, oa, wb, ob;
   logic [7:0] addr, wd, rdat, v;
   logic [2:0] ack;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   tmr_core DUT (.mclk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .global_irq_en_i(gie),
      .vector_ack_i(ack), .irq_match_b_o(ib), .irq_match_a_o(ia), .irq_wrap_o(iw),
      .ext_count_pin_i(ext), .wave_out_a_o(wa), .wave_oe_a_o(oa), .wave_out_b_o(wb),
      .wave_oe_b_o(ob));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic summarize();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdat;
   endtask
   task automatic rde(input logic [7:0] a, input logic [7:0] e);
      rd8(a);
      chk8(v, e);
   endtask
   // Write then read with no gap
   task automatic wrb(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      wrt(a, d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk8(rdat, e);
   endtask
   task automatic pin(input logic lvl);
      @(posedge clk);
      ext <= lvl;
      cyc(6);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_access();
      rde(ra, 8'h00);
      rde(rb, 8'h00);
      rde(rc, 8'h00);
      rde(rm, 8'h00);
      rde(rf, 8'h00);
      wrb(rm, 8'hFF, 8'h07);
      wrb(ra, 8'hFF, 8'hF3);
      wrb(rb, 8'hF8, 8'h08);
      wrb(rpa, 8'hA5, 8'hA5);
      rde(8'h80, 8'h00);
      wrt(ra, 8'h00);
      wrt(rb, 8'h00);
   endtask
   task automatic t_count();
      wrb(rc, 8'h5A, 8'h5A);
      wrt(rpb, 8'h20);
      wrt(rb, 8'h01);
      wrt(rc, 8'h20);
      cyc(3);
      wrt(rb, 8'h00);
      rde(rf, 8'h00);
      wrt(rc, 8'h1E);
      wrt(rb, 8'h01);
      cyc(4);
      wrt(rb, 8'h00);
      rde(rf, 8'h04);
      chk1(ib, 1'b1);
      wrt(rf, 8'h04);
      cyc(1);
      chk1(ib, 1'b0);
      rde(rf, 8'h00);
   endtask
   task automatic t_wrap();
      wrt(rc, 8'hFD);
      wrt(rb, 8'h01);
      cyc(6);
      wrt(rb, 8'h00);
      chk1(iw, 1'b1);
      rde(rf, 8'h01);
      @(posedge clk);
      gie <= 1'b0;
      cyc(1);
      chk1(iw, 1'b0);
      @(posedge clk);
      gie <= 1'b1;
      ack <= 3'b001;
      @(posedge clk);
      ack <= 3'b000;
      rde(rf, 8'h00);
      chk1(iw, 1'b0);
   endtask
   task automatic t_mode();
      wrt(rpa, 8'h05);
      wrt(rc, 8'h00);
      wrt(ra, 8'h02);
      wrt(rb, 8'h01);
      cyc(40);
      wrt(rb, 8'h00);
      rd8(rc);
      chk1(v <= 8'h05, 1'b1);
      rde(rf, 8'h02);
      chk1(ia, 1'b1);
      wrt(rf, 8'h07);
      wrt(rc, 8'h00);
      wrt(rb, 8'h09);
      cyc(20);
      wrt(rb, 8'h08);
      rd8(rc);
      chk1(v > 8'h05, 1'b1);
      wrt(rc, 8'h00);
      wrt(ra, 8'h03);
      wrt(rb, 8'h09);
      cyc(40);
      wrt(rb, 8'h08);
      rd8(rc);
      chk1(v <= 8'h05, 1'b1);
      rde(rf, 8'h03);
      // Phase-correct, ceiling compare A: nine ticks end on the way down
      wrt(rf, 8'h07);
      wrt(rc, 8'h00);
      wrt(ra, 8'h01);
      wrt(rb, 8'h09);
      cyc(7);
      wrt(rb, 8'h08);
      rde(rc, 8'h01);
      rde(rf, 8'h03);
      wrt(ra, 8'h00);
      wrt(rb, 8'h00);
      wrt(rf, 8'h07);
   endtask
   task automatic t_force();
      wrt(rc, 8'h33);
      wrt(ra, 8'hC0);
      cyc(1);
      chk1(oa, 1'b1);
      wrt(rb, 8'h80);
      cyc(2);
      chk1(wa, 1'b1);
      wrt(ra, 8'h80);
      wrt(rb, 8'h80);
      cyc(2);
      chk1(wa, 1'b0);
      wrt(ra, 8'h40);
      wrt(rb, 8'h80);
      cyc(2);
      chk1(wa, 1'b1);
      wrt(ra, 8'h30);
      wrt(rb, 8'h40);
      cyc(2);
      chk1(wb, 1'b1);
      chk1(ob, 1'b1);
      rde(rc, 8'h33);
      rde(rf, 8'h00);
      wrt(ra, 8'h00);
   endtask
   task automatic t_clock();
      int sh[4] = '{3, 6, 8, 10};
      int e;
      wrt(rc, 8'h00);
      wrt(rb, 8'h07);
      pin(1'b1);
      pin(1'b0);
      wrt(rb, 8'h00);
      rde(rc, 8'h01);
      wrt(rb, 8'h06);
      pin(1'b1);
      pin(1'b0);
      wrt(rb, 8'h00);
      rde(rc, 8'h02);
      for (int i = 0; i < 4; i++)
      begin
         e = 1100 >> sh[i];
         wrt(rc, 8'h00);
         wrt(rb, 8'(i + 2));
         cyc(1100);
         wrt(rb, 8'h00);
         rd8(rc);
         chk1(v >= 8'(e - 1) && v <= 8'(e + 1), 1'b1);
         cyc(5);
         rde(rc, v);
      end
   endtask

   // Main sequence
   initial
   begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      gie = 1'b1;
      ext = 1'b0;
      ack = 3'b000;
      addr = 8'h00;
      wd = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_access();
      t_count();
      t_wrap();
      t_mode();
      t_force();
      t_clock();
      summarize();
   end
endmodule // tmr_core_bench

bind tmr_core tmr_core_props chk (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .global_irq_en_i, .vector_ack_i, .irq_match_b_o, .irq_match_a_o,
   .irq_wrap_o, .ext_count_pin_i, .wave_out_a_o, .wave_oe_a_o, .wave_out_b_o, .wave_oe_b_o);
`default_nettype wire
